// ### verif/tco_chk.sv
// port-level assertions of the timer compare port block
`timescale 1ns/10ps
`default_nettype none
module tco_chk (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // apb slave
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // port pins and requests
    input wire logic [7:0] port_out,
    input wire logic [8:0] irq_req
);
    logic [3:0] ph_q;

    // phase of the machine cycle, 0 = S1P1, counted from reset like the block
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) ph_q <= 4'h0;
        else ph_q <= (ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    chk_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("pready missing in access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without setup");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    // only S5P1 (hardware) and S1P1 (software) edges may move the pins
    chk_port_phase: assert property (!$stable(port_out) |-> ph_q == 4'h1 || ph_q == 4'h9)
        else $error("port changed off its phases");
    chk_irq_scan_s2: assert property (!$stable({irq_req[8:7], irq_req[4], irq_req[0]}) |-> ph_q == 4'h3)
        else $error("s2 request moved off scan");
    chk_irq_scan_s3: assert property (!$stable({irq_req[5], irq_req[1]}) |-> ph_q == 4'h5)
        else $error("s3 request moved off scan");
    chk_irq_scan_s4: assert property (!$stable({irq_req[6], irq_req[2]}) |-> ph_q == 4'h7)
        else $error("s4 request moved off scan");
    chk_irq_scan_s5: assert property (!$stable(irq_req[3]) |-> ph_q == 4'h9)
        else $error("s5 request moved off scan");
endmodule
`default_nettype wire

// ### verif/tco_core_bench.sv
// self-checking bench of the timer compare port block
`timescale 1ns/10ps
`default_nettype none
module tco_core_bench;
    import tco_pkg::*;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        go, tmr_inc, wide_ovf_evt, byte_ovf_evt, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] target, tmr_value;
    logic [3:0]  capture_evt;
    logic [7:0]  port_out;
    logic [8:0]  irq_req, irq_high;
    int          fail_count, n_checks;

    tco_core u_tco_core (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tmr_value(tmr_value), .tmr_inc(tmr_inc),
        .capture_evt(capture_evt), .wide_ovf_evt(wide_ovf_evt), .byte_ovf_evt(byte_ovf_evt),
        .port_out(port_out), .irq_req(irq_req), .irq_high(irq_high));
    tco_timer_model u_tco_timer_model (.clk_sys(clk_sys), .rst(rst), .go(go),
        .target(target), .tmr_value(tmr_value), .tmr_inc(tmr_inc));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            // a slave that never answers ends the run here
            fail_count++;
            close_out();
        end
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 32'h0);
        chk(what, exp, rdv);
    endtask

    task automatic hit(input logic [15:0] t);
        @(posedge clk_sys);
        go     <= 1'b1;
        target <= t;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask

    task automatic wait_mc(input int n);
        repeat (12 * n) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        chk("port", 32'hFF, {24'h0, port_out});
        rd(TCO_IDX_FLAGS, 32'h00, "flags");
        rd(TCO_IDX_SETEN, 32'hC0, "seten");
        rd(TCO_IDX_CLRTG, 32'h00, "clrtg");
        rd(TCO_IDX_PRIO, 32'h00, "prio");
        rd(TCO_IDX_CMPA, 32'h0, "cmpa");
        rd(TCO_IDX_CMPB, 32'h0, "cmpb");
        rd(TCO_IDX_CMPC, 32'h0, "cmpc");
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, errv});
    endtask

    task automatic t_toggle();
        apb(1'b1, TCO_IDX_PORT, 32'h00);
        wait_mc(1);
        chk("port sw", 32'h00, {24'h0, port_out});
        apb(1'b1, TCO_IDX_CLRTG, 32'hC0);
        apb(1'b1, TCO_IDX_CMPC, 32'h9);
        hit(16'h0009);
        wait_mc(3);
        chk("port tog1", 32'hC0, {24'h0, port_out});
        rd(TCO_IDX_SETEN, 32'h00, "tog state");
        // latch cleared by software: next toggle still clears
        apb(1'b1, TCO_IDX_PORT, 32'h00);
        hit(16'h0009);
        wait_mc(3);
        chk("port tog2", 32'h00, {24'h0, port_out});
        rd(TCO_IDX_SETEN, 32'hC0, "tog state");
    endtask

    task automatic t_setclr();
        apb(1'b1, TCO_IDX_SETEN, 32'h3F);
        rd(TCO_IDX_SETEN, 32'hFF, "seten ro");
        apb(1'b1, TCO_IDX_CMPA, 32'hC);
        apb(1'b1, TCO_IDX_CMPB, 32'hC);
        apb(1'b1, TCO_IDX_CLRTG, 32'h01);
        hit(16'h000C);
        wait_mc(3);
        chk("port set", 32'h3E, {24'h0, port_out});
        apb(1'b1, TCO_IDX_CMPB, 32'h14);
        apb(1'b1, TCO_IDX_CLRTG, 32'h06);
        hit(16'h0014);
        wait_mc(3);
        chk("port clr", 32'h38, {24'h0, port_out});
    endtask

    task automatic t_flags();
        rd(TCO_IDX_FLAGS, 32'h70, "match flags");
        chk("irq req", 32'h070, {23'h0, irq_req});
        apb(1'b1, TCO_IDX_PRIO, 32'h10);
        // priority lands with the write, the output register follows one edge later
        repeat (2) @(posedge clk_sys);
        chk("irq high", 32'h010, {23'h0, irq_high});
        apb(1'b1, TCO_IDX_FLAGS, 32'h00);
        wait_mc(2);
        rd(TCO_IDX_FLAGS, 32'h00, "flags clr");
        chk("irq clr", 32'h000, {23'h0, irq_req});
    endtask

    task automatic t_events();
        @(posedge clk_sys);
        capture_evt  <= 4'hF;
        wide_ovf_evt <= 1'b1;
        byte_ovf_evt <= 1'b1;
        @(posedge clk_sys);
        capture_evt  <= 4'h0;
        wide_ovf_evt <= 1'b0;
        byte_ovf_evt <= 1'b0;
        wait_mc(2);
        rd(TCO_IDX_FLAGS, 32'h8F, "event flags");
        rd(TCO_IDX_TCTL, 32'h10, "byte ovf");
        chk("irq ev", 32'h18F, {23'h0, irq_req});
        apb(1'b1, TCO_IDX_PRIO, 32'h80);
        repeat (2) @(posedge clk_sys);
        chk("irq high ovf", 32'h180, {23'h0, irq_high});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, go, wide_ovf_evt, byte_ovf_evt} = 6'h00;
        {paddr, pwdata, target, capture_evt} = 64'h0;
        fail_count = 0;
        n_checks = 0;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_toggle();
        t_setclr();
        t_flags();
        t_events();
        close_out();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end
endmodule

bind tco_core tco_chk u_tco_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .port_out(port_out),
    .irq_req(irq_req));
`default_nettype wire

// ### verif/tco_timer_model.sv
// timer partner: jumps to a wanted count and pulses the increment
`timescale 1ns/10ps
`default_nettype none
module tco_timer_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // request from the bench
    input  wire logic        go,
    input  wire logic [15:0] target,
    // timer outputs
    output logic      [15:0] tmr_value,
    output logic             tmr_inc
);
    // the new count lands with the pulse, since the block compares the new value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tmr_value <= 16'h0000;
            tmr_inc   <= 1'b0;
        end else begin
            tmr_inc <= go;
            if (go) tmr_value <= target;
        end
    end
endmodule
`default_nettype wire

// ### verilog/tco_core.sv
// compare-driven output port, timer event flags and priority of the 16-bit timer
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tco_core
    import tco_pkg::*;
#(
    parameter int TMR_W = TCO_TMR_W
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [TCO_AW-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // timer side, same clock domain
    input  wire logic [TMR_W-1:0]     tmr_value,
    input  wire logic                 tmr_inc,
    input  wire logic [3:0]           capture_evt,
    input  wire logic                 wide_ovf_evt,
    input  wire logic                 byte_ovf_evt,
    // port pins and interrupt controller
    output logic      [7:0]           port_out,
    output logic      [8:0]           irq_req,
    output logic      [8:0]           irq_high
);

    typedef struct packed {
        tco_phase_t         ph;
        logic [TMR_W-1:0]   cmp_a;
        logic [TMR_W-1:0]   cmp_b;
        logic [TMR_W-1:0]   cmp_c;
        logic [5:0]         set_en;
        logic [1:0]         tg;
        logic [7:0]         clr_en;
        logic [7:0]         flags;
        logic               bovf;
        logic [7:0]         prio;
        logic [7:0]         port;
        logic [7:0]         sw_val;
        logic               sw_pend;
        logic [2:0]         m_pend;
        logic [2:0]         m_prev;
        logic [3:0]         c_pend;
        logic [1:0]         o_pend;
        logic [8:0]         irq;
        logic [8:0]         irqh;
        logic [31:0]        rdata;
        logic               rdy;
        logic               err;
    } tco_state_t;

    tco_state_t s_q;
    tco_state_t s_d;

    function automatic logic hit(input logic [TCO_AW-1:0] a, input logic [7:0] idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic mapped(input logic [TCO_AW-1:0] a);
        mapped = hit(a, TCO_IDX_FLAGS) | hit(a, TCO_IDX_SETEN) | hit(a, TCO_IDX_CLRTG)
               | hit(a, TCO_IDX_PRIO) | hit(a, TCO_IDX_PORT) | hit(a, TCO_IDX_TCTL)
               | hit(a, TCO_IDX_CMPA) | hit(a, TCO_IDX_CMPB) | hit(a, TCO_IDX_CMPC);
    endfunction

    logic       wr_now;
    logic [7:0] wb;
    logic [2:0] match;
    logic [7:0] fset;
    logic [7:0] hw_set;
    logic [7:0] hw_clr;
    logic [7:0] hw_mask;
    logic [7:0] hw_port;
    logic [1:0] tg_next;
    logic [8:0] scan;

    always_comb begin
        s_d     = s_q;
        wr_now  = psel & penable & pwrite & s_q.rdy & ~s_q.err;
        wb      = pwdata[7:0];
        fset    = 8'h00;
        hw_set  = 8'h00;
        hw_clr  = 8'h00;
        tg_next = s_q.tg;
        scan    = 9'h000;

        // tmr_value already holds the incremented count when tmr_inc pulses
        match[0] = tmr_inc & (tmr_value == s_q.cmp_a);
        match[1] = tmr_inc & (tmr_value == s_q.cmp_b);
        match[2] = tmr_inc & (tmr_value == s_q.cmp_c);

        // machine cycle phase sequencer, one phase per clock
        case (s_q.ph)
            PH_S1P1: s_d.ph = PH_S1P2;
            PH_S1P2: s_d.ph = PH_S2P1;
            PH_S2P1: s_d.ph = PH_S2P2;
            PH_S2P2: s_d.ph = PH_S3P1;
            PH_S3P1: s_d.ph = PH_S3P2;
            PH_S3P2: s_d.ph = PH_S4P1;
            PH_S4P1: s_d.ph = PH_S4P2;
            PH_S4P2: s_d.ph = PH_S5P1;
            PH_S5P1: s_d.ph = PH_S5P2;
            PH_S5P2: s_d.ph = PH_S6P1;
            PH_S6P1: s_d.ph = PH_S6P2;
            PH_S6P2: s_d.ph = PH_S1P1;
            default: s_d.ph = PH_S1P1;
        endcase

        // events wait for their set phase
        s_d.c_pend = s_q.c_pend | capture_evt;
        s_d.o_pend = s_q.o_pend | {byte_ovf_evt, wide_ovf_evt};
        s_d.m_pend = s_q.m_pend | match;

        if (s_q.ph == PH_S4P1) begin
            fset[1:0]       = s_q.c_pend[1:0];
            s_d.c_pend[1:0] = capture_evt[1:0];
        end
        if (s_q.ph == PH_S6P1) begin
            fset[3:2]       = s_q.c_pend[3:2];
            s_d.c_pend[3:2] = capture_evt[3:2];
            fset[6:4]       = s_q.m_prev;
            fset[7]         = s_q.o_pend[0];
            s_d.o_pend      = {byte_ovf_evt, wide_ovf_evt};
        end
        if (s_q.ph == PH_S6P2) begin
            // matches of this cycle act during the next one
            s_d.m_prev = s_q.m_pend | match;
            s_d.m_pend = 3'b000;
        end

        // compare actions on the port, applied at S5P1 of the following cycle
        if (s_q.ph == PH_S5P1) begin
            if (s_q.m_prev[0]) begin
                hw_set[5:0] = s_q.set_en;
            end
            if (s_q.m_prev[1]) begin
                hw_clr[5:0] = s_q.clr_en[5:0];
            end
            if (s_q.m_prev[2]) begin
                for (int i = 0; i < 2; i++) begin
                    if (s_q.clr_en[TCO_TG_LO+i]) begin
                        // latch takes the stored operation, the state flips
                        hw_set[TCO_TG_LO+i] = s_q.tg[i];
                        hw_clr[TCO_TG_LO+i] = ~s_q.tg[i];
                        tg_next[i]          = ~s_q.tg[i];
                    end
                end
            end
        end
        hw_mask = hw_set | hw_clr;
        hw_port = (s_q.port | hw_set) & ~hw_clr;
        s_d.tg  = tg_next;

        // software port write waits for S1P1 of the next cycle
        if (s_q.ph == PH_S1P1 && s_q.sw_pend) begin
            s_d.port    = s_q.sw_val;
            s_d.sw_pend = 1'b0;
        end else begin
            s_d.port = hw_port;
        end
        if (wr_now && hit(paddr, TCO_IDX_PORT)) begin
            s_d.sw_pend = 1'b1;
            s_d.sw_val  = wb;
        end
        // a pending software value is overridden where hardware acted
        if (s_d.sw_pend) begin
            s_d.sw_val = (s_d.sw_val & ~hw_mask) | (hw_port & hw_mask);
        end

        // flags: write replaces, hardware set wins over a write of 0
        if (wr_now && hit(paddr, TCO_IDX_FLAGS)) begin
            s_d.flags = wb;
        end
        s_d.flags = s_d.flags | fset;
        if (wr_now && hit(paddr, TCO_IDX_TCTL)) begin
            s_d.bovf = wb[TCO_TCTL_BOVF];
        end
        if (s_q.ph == PH_S6P1 && s_q.o_pend[1]) begin
            s_d.bovf = 1'b1;
        end

        // other register writes
        if (wr_now) begin
            if (hit(paddr, TCO_IDX_SETEN)) begin
                s_d.set_en = wb[5:0];
            end
            if (hit(paddr, TCO_IDX_CLRTG)) begin
                s_d.clr_en = wb;
            end
            if (hit(paddr, TCO_IDX_PRIO)) begin
                s_d.prio = wb;
            end
            if (hit(paddr, TCO_IDX_CMPA)) begin
                s_d.cmp_a = pwdata[TMR_W-1:0];
            end
            if (hit(paddr, TCO_IDX_CMPB)) begin
                s_d.cmp_b = pwdata[TMR_W-1:0];
            end
            if (hit(paddr, TCO_IDX_CMPC)) begin
                s_d.cmp_c = pwdata[TMR_W-1:0];
            end
        end

        // interrupt scan: each request samples its flag in its own phase
        case (s_q.ph)
            PH_S2P1: scan = TCO_SCAN_S2;
            PH_S3P1: scan = TCO_SCAN_S3;
            PH_S4P1: scan = TCO_SCAN_S4;
            PH_S5P1: scan = TCO_SCAN_S5;
            default: scan = 9'h000;
        endcase
        s_d.irq  = (s_q.irq & ~scan) | ({s_q.bovf, s_q.flags} & scan);
        s_d.irqh = {s_q.prio[7], s_q.prio};

        // apb: answer registered in setup, ready for one access cycle
        s_d.rdy   = psel & ~penable;
        s_d.err   = psel & ~penable & ~mapped(paddr);
        s_d.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, TCO_IDX_FLAGS)) begin
                s_d.rdata[7:0] = s_q.flags;
            end
            if (hit(paddr, TCO_IDX_SETEN)) begin
                s_d.rdata[7:0] = {s_q.tg, s_q.set_en};
            end
            if (hit(paddr, TCO_IDX_CLRTG)) begin
                s_d.rdata[7:0] = s_q.clr_en;
            end
            if (hit(paddr, TCO_IDX_PRIO)) begin
                s_d.rdata[7:0] = s_q.prio;
            end
            if (hit(paddr, TCO_IDX_PORT)) begin
                s_d.rdata[7:0] = s_q.port;
            end
            if (hit(paddr, TCO_IDX_TCTL)) begin
                s_d.rdata[TCO_TCTL_BOVF] = s_q.bovf;
            end
            if (hit(paddr, TCO_IDX_CMPA)) begin
                s_d.rdata[TMR_W-1:0] = s_q.cmp_a;
            end
            if (hit(paddr, TCO_IDX_CMPB)) begin
                s_d.rdata[TMR_W-1:0] = s_q.cmp_b;
            end
            if (hit(paddr, TCO_IDX_CMPC)) begin
                s_d.rdata[TMR_W-1:0] = s_q.cmp_c;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q.ph      <= PH_S1P1;
            s_q.cmp_a   <= '0;
            s_q.cmp_b   <= '0;
            s_q.cmp_c   <= '0;
            s_q.set_en  <= TCO_RST_SETEN[5:0];
            s_q.tg      <= TCO_RST_SETEN[7:6];
            s_q.clr_en  <= TCO_RST_CLRTG;
            s_q.flags   <= TCO_RST_FLAGS;
            s_q.bovf    <= 1'b0;
            s_q.prio    <= TCO_RST_PRIO;
            s_q.port    <= TCO_RST_PORT;
            s_q.sw_val  <= 8'h00;
            s_q.sw_pend <= 1'b0;
            s_q.m_pend  <= 3'b000;
            s_q.m_prev  <= 3'b000;
            s_q.c_pend  <= 4'h0;
            s_q.o_pend  <= 2'b00;
            s_q.irq     <= 9'h000;
            s_q.irqh    <= 9'h000;
            s_q.rdata   <= 32'h0000_0000;
            s_q.rdy     <= 1'b0;
            s_q.err     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata   = s_q.rdata;
    assign pready   = s_q.rdy;
    assign pslverr  = s_q.err;
    assign port_out = s_q.port;
    assign irq_req  = s_q.irq;
    assign irq_high = s_q.irqh;

endmodule
`default_nettype wire

// ### verilog/tco_pkg.sv
// constants, phase type and register map of the timer compare port block
// Notes on behaviour
// - toggle state alternates regardless of software writes to the port latch
// - first toggle after reset drives the port bit high
// - toggle states read at set-enable bits 6 and 7, writes ignored
// - toggle state 1 means next toggle sets, 0 means next toggle clears
// - all three compare values cleared by reset
// - compare-driven latch change reaches pin at S5P1 of next cycle
// - software port write reaches pin at S1P1 of next cycle
// - every port bit settable and clearable by software at any time
// - compare update beats software update in the same cycle
// - simultaneous set and clear requests leave the bit cleared
// - nine flags: eight in event register, byte overflow at control bit 4
// - capture flags a,b set in S4; scanned in S2 and S3
// - capture flags c,d set in S6; scanned in S4 and S5
// - capture requests recognised in the cycle after the flag sets
// - polled capture a,b seen in S4, two states before c,d in S6, for same event arriving before S4
// - match flags set in S6 after match; scanned S2, S3, S4
// - match visible to interrupts and polling two cycles after match
// - both overflow flags set in S6, recognised next cycle
// - priority bit 1 gives high priority, 0 low priority
// - match a sets port bits 0-5 whose set enable is 1
// - match b clears port bits 0-5 whose clear enable is 1
// - match c toggles port bits 6,7 whose toggle enable is 1
// - toggle flips a dedicated state flip-flop, latch copies it
package tco_pkg;
    localparam int TCO_TMR_W = 16;
    localparam int TCO_AW    = 12;

    // register indices; byte address is four times the index
    localparam logic [7:0] TCO_IDX_FLAGS = 8'hC8;
    localparam logic [7:0] TCO_IDX_SETEN = 8'hEE;
    localparam logic [7:0] TCO_IDX_CLRTG = 8'hEF;
    localparam logic [7:0] TCO_IDX_PRIO  = 8'hF8;
    localparam logic [7:0] TCO_IDX_PORT  = 8'hC0;
    localparam logic [7:0] TCO_IDX_TCTL  = 8'hC9;
    localparam logic [7:0] TCO_IDX_CMPA  = 8'hD0;
    localparam logic [7:0] TCO_IDX_CMPB  = 8'hD1;
    localparam logic [7:0] TCO_IDX_CMPC  = 8'hD2;

    localparam logic [7:0] TCO_RST_FLAGS = 8'h00;
    localparam logic [7:0] TCO_RST_SETEN = 8'hC0;
    localparam logic [7:0] TCO_RST_CLRTG = 8'h00;
    localparam logic [7:0] TCO_RST_PRIO  = 8'h00;
    localparam logic [7:0] TCO_RST_PORT  = 8'hFF;

    localparam int TCO_TCTL_BOVF = 4;
    localparam int TCO_TG_LO     = 6;

    // flag order: cap a..d, match a..c, wide ovf, byte ovf
    localparam logic [8:0] TCO_SCAN_S2 = 9'h191;
    localparam logic [8:0] TCO_SCAN_S3 = 9'h022;
    localparam logic [8:0] TCO_SCAN_S4 = 9'h044;
    localparam logic [8:0] TCO_SCAN_S5 = 9'h008;

    typedef enum logic [11:0] {
        PH_S1P1 = 12'h001,
        PH_S1P2 = 12'h002,
        PH_S2P1 = 12'h004,
        PH_S2P2 = 12'h008,
        PH_S3P1 = 12'h010,
        PH_S3P2 = 12'h020,
        PH_S4P1 = 12'h040,
        PH_S4P2 = 12'h080,
        PH_S5P1 = 12'h100,
        PH_S5P2 = 12'h200,
        PH_S6P1 = 12'h400,
        PH_S6P2 = 12'h800
    } tco_phase_t;
endpackage
